// file: rtl/lfg_frame_geometry_regs.sv
// Purpose: frame geometry registers with AXI4-Lite slave and line fetch sequencer
// Assumes: software keeps image inside one 1 Mbyte region
// Notes: registers zero after reset
// Function
// [R1] Each frame's fetch starts at the start address field held in bits 31 to 1.
// [R2] Software keeps the whole image inside one 1 Mbyte region, upper bits fixed.
// [R3] Software writes zero to bit 0 of the start address register.
// [R4] The virtual page width register holds the stored width in 16-bit words in bits 7 to 0.
// [R5] Software sets the word count as pixels over 16, 8 or 4 by gray mode.
// [R6] Software programs the screen width as a multiple of 16 pixels.
// [R7] The screen width register keeps bits 9 to 4 and reads zero elsewhere.
// [R8] The screen height register keeps 9 bits and the frame has that value plus one lines.
// [R9] Gray mode codes are 00 mono, 01 four-level, 10 sixteen-level, 11 reserved.
// [R10] Each next line starts one virtual page width further in memory.
`timescale 1ns/1ps
`default_nettype none
`include "lfg_defines.svh"
module lfg_frame_geometry_regs #(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pixel fetch side
  input wire logic frame_start,
  output logic line_req,
  input wire logic line_ack,
  output logic [31:0] line_addr,
  output logic [8:0] line_idx,
  output logic [1:0] gray_mode_select
);
  // offsets need sixteen address bits
  if (ADDR_W < 16) begin : g_addr_w_check
    $error("ADDR_W must be at least 16");
  end
  logic [31:0] start_q;
  logic [7:0] vpw_q;
  logic [5:0] width_q;
  logic [8:0] height_q;
  logic [1:0] mode_q;
  logic aw_held_q, w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic frame_busy, region_err;
  lfg_geom_if geom ();
  wire do_write = aw_held_q && w_held_q && !bvalid_q;
  wire [15:0] wa = awaddr_q[15:0];
  wire [15:0] ra = s_axi_araddr[15:0];
  wire hit_start_w = (wa == `LFG_OFS_START);
  wire hit_vpw_w = (wa == `LFG_OFS_VPW);
  wire hit_width_w = (wa == `LFG_OFS_WIDTH);
  wire hit_height_w = (wa == `LFG_OFS_HEIGHT);
  wire hit_mode_w = (wa == `LFG_OFS_MODE);
  wire w_mapped = hit_start_w | hit_vpw_w | hit_width_w | hit_height_w | hit_mode_w;
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] start_merge = (start_q & ~wmask) | (wdata_q & wmask);
  wire [31:0] width_word = {22'h000000, width_q, 4'h0};
  wire [31:0] width_merge = (width_word & ~wmask) | (wdata_q & wmask);
  wire [31:0] height_merge = ({23'h000000, height_q} & ~wmask) | (wdata_q & wmask);
  wire rd_go = s_axi_arvalid && !rvalid_q;
  wire [31:0] start_rd = {start_q[`LFG_SSA_MSB:`LFG_SSA_LSB], 1'b0};
  wire r_start = (ra == `LFG_OFS_START);
  wire r_vpw = (ra == `LFG_OFS_VPW);
  wire r_width = (ra == `LFG_OFS_WIDTH);
  wire r_height = (ra == `LFG_OFS_HEIGHT);
  wire r_mode = (ra == `LFG_OFS_MODE);
  wire r_status = (ra == `LFG_OFS_STATUS);
  wire r_mapped = r_start | r_vpw | r_width | r_height | r_mode | r_status;
  wire [31:0] rd_mux =
    r_start ? start_rd :
    r_vpw ? {24'h000000, vpw_q} :
    r_width ? width_word : // [R7]
    r_height ? {23'h000000, height_q} :
    r_mode ? {30'h00000000, mode_q} :
    r_status ? {30'h00000000, region_err, frame_busy} : 32'h00000000;
  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready = !w_held_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign geom.start_addr = {start_q[`LFG_SSA_MSB:`LFG_SSA_LSB], 1'b0}; // [R1]
  assign geom.page_word_count = vpw_q; // [R4]
  assign geom.width_px = {width_q, 4'h0}; // [R7]
  assign geom.height_minus_one = height_q; // [R8]
  assign geom.gray_mode_select = lfg_pkg::lfg_gray_e'(mode_q); // [R9]
  assign gray_mode_select = mode_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_q <= `LFG_REG_RESET;
      vpw_q <= 8'h00;
      width_q <= 6'h00;
      height_q <= 9'h000;
      mode_q <= 2'b00;
      bvalid_q <= 1'b0;
      bresp_q <= `LFG_RESP_OKAY;
    end else begin
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= w_mapped ? `LFG_RESP_OKAY : `LFG_RESP_SLVERR;
        if (hit_start_w) start_q <= {start_merge[31:1], 1'b0}; // [R1]
        if (hit_vpw_w && wstrb_q[0]) vpw_q <= wdata_q[`LFG_VPW_MSB:0]; // [R4]
        if (hit_width_w) width_q <= width_merge[`LFG_XM_MSB:`LFG_XM_LSB]; // [R7]
        if (hit_height_w) height_q <= height_merge[`LFG_YM_MSB:0]; // [R8]
        if (hit_mode_w && wstrb_q[0] && wdata_q[1:0] != 2'b11) mode_q <= wdata_q[1:0]; // [R9]
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `LFG_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= r_mapped ? `LFG_RESP_OKAY : `LFG_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  lfg_fetch_seq u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .geom(geom),
    .frame_start(frame_start),
    .line_req(line_req),
    .line_ack(line_ack),
    .line_addr_q(line_addr),
    .line_idx_q(line_idx),
    .frame_busy(frame_busy),
    .region_err_q(region_err)
  );
  AST_WIDTH_RSVD: assert property (@(posedge aclk) disable iff (!aresetn)
    (rvalid_q && $past(rd_go) && $past(r_width)) |-> (rdata_q[31:10] == 22'h0 && rdata_q[3:0] == 4'h0))
    else $error("width reserved bits not zero"); // [R7]
  AST_START_BIT0: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && hit_start_w |=> start_q[0] == 1'b0 && start_q[31:1] == $past(start_merge[31:1]))
    else $error("start address not stored"); // [R1]
  AST_VPW_STORE: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && hit_vpw_w && wstrb_q[0] |=> vpw_q == $past(wdata_q[7:0]))
    else $error("page width not stored"); // [R4]
  AST_HEIGHT_STORE: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && hit_height_w && (&wstrb_q) |=> height_q == $past(wdata_q[8:0]))
    else $error("height not stored"); // [R8]
  AST_MODE_RSVD: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_q != 2'b11)
    else $error("reserved gray mode taken"); // [R9]
  AST_WRESP: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> bvalid_q)
    else $error("no write response");
  AST_WIDTH_STORE: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && hit_width_w && (&wstrb_q) |=> width_q == $past(wdata_q[9:4]))
    else $error("width not stored"); // [R7]
  AST_MODE_KEEP: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && hit_mode_w && wdata_q[1:0] == 2'b11 |=> $stable(mode_q))
    else $error("reserved gray mode write changed mode"); // [R9]
  AST_BAD_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && !w_mapped |=> $stable(start_q) && $stable(vpw_q) && $stable(width_q) &&
      $stable(height_q) && $stable(mode_q) && bresp_q == `LFG_RESP_SLVERR)
    else $error("unmapped write had an effect");
  AST_BAD_READ: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_go && !r_mapped |=> rdata_q == 32'h00000000 && rresp_q == `LFG_RESP_SLVERR)
    else $error("unmapped read not refused");
  AST_RRESP: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_go |=> rvalid_q)
    else $error("no read response");
  AST_R_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid_q && s_axi_rready |=> !rvalid_q)
    else $error("read data held after it was taken");
  AST_B_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid_q && s_axi_bready |=> !bvalid_q)
    else $error("write response held after it was taken");
  COV_WRITE: cover property (@(posedge aclk) disable iff (!aresetn) do_write && hit_start_w);
  COV_READ: cover property (@(posedge aclk) disable iff (!aresetn) rd_go && r_status);
  COV_BAD: cover property (@(posedge aclk) disable iff (!aresetn) do_write && !w_mapped);
endmodule
`default_nettype wire

// file: rtl/lfg_defines.svh
// Purpose: offsets, field positions, reset values for frame geometry block
// Assumes: AXI4-Lite byte addresses
// Notes: only start address offset is fixed; others follow it
`ifndef LFG_DEFINES_SVH
`define LFG_DEFINES_SVH
`define LFG_OFS_START 16'hfa00
`define LFG_OFS_VPW 16'hfa04
`define LFG_OFS_WIDTH 16'hfa08
`define LFG_OFS_HEIGHT 16'hfa0c
`define LFG_OFS_MODE 16'hfa10
`define LFG_OFS_STATUS 16'hfa14
`define LFG_SSA_MSB 31
`define LFG_SSA_LSB 1
`define LFG_VPW_MSB 7
`define LFG_XM_MSB 9
`define LFG_XM_LSB 4
`define LFG_YM_MSB 8
`define LFG_REG_RESET 32'h00000000
`define LFG_RESP_OKAY 2'b00
`define LFG_RESP_SLVERR 2'b10
`define LFG_REGION_LSB 20
`endif

// file: rtl/lfg_pkg.sv
// Purpose: types for frame geometry block
// Assumes: none
// Notes: gray modes and fetch states
package lfg_pkg;
  typedef enum logic [1:0] {
    LFG_GS_BW = 2'b00,
    LFG_GS_GRAY4 = 2'b01,
    LFG_GS_GRAY16 = 2'b10,
    LFG_GS_RSVD = 2'b11
  } lfg_gray_e;
  typedef enum logic [1:0] {
    LFG_IDLE,
    LFG_LINE,
    LFG_NEXT
  } lfg_fetch_e;
endpackage

// file: rtl/lfg_geom_if.sv
// Purpose: carries programmed geometry from register file to fetch sequencer
// Assumes: single clock
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface lfg_geom_if;
  logic [31:0] start_addr;
  logic [7:0] page_word_count;
  logic [9:0] width_px;
  logic [8:0] height_minus_one;
  lfg_pkg::lfg_gray_e gray_mode_select;
  modport src (output start_addr, page_word_count, width_px, height_minus_one,
    gray_mode_select);
  modport dst (input start_addr, page_word_count, width_px, height_minus_one,
    gray_mode_select);
endinterface
`default_nettype wire

// file: rtl/lfg_fetch_seq.sv
// Purpose: walks frame lines and emits line fetch addresses
// Assumes: fetch side acknowledges each line request
// Notes: address advance uses word count in bytes
`timescale 1ns/1ps
`default_nettype none
`include "lfg_defines.svh"
module lfg_fetch_seq (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // geometry
  lfg_geom_if.dst geom,
  // frame control
  input wire logic frame_start,
  // line fetch request
  output logic line_req,
  input wire logic line_ack,
  output logic [31:0] line_addr_q,
  output logic [8:0] line_idx_q,
  output logic frame_busy,
  output logic region_err_q
);
  lfg_pkg::lfg_fetch_e state_q;
  logic [31:0] line_step;
  logic last_line;
  assign line_step = {23'h000000, geom.page_word_count, 1'b0};
  assign last_line = (line_idx_q == geom.height_minus_one); // [R8]
  assign line_req = (state_q == lfg_pkg::LFG_LINE);
  assign frame_busy = (state_q != lfg_pkg::LFG_IDLE);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= lfg_pkg::LFG_IDLE;
      line_addr_q <= 32'h00000000;
      line_idx_q <= 9'h000;
      region_err_q <= 1'b0;
    end else begin
      case (state_q)
        lfg_pkg::LFG_IDLE: begin
          if (frame_start) begin
            line_addr_q <= {geom.start_addr[31:1], 1'b0}; // [R1]
            line_idx_q <= 9'h000;
            region_err_q <= 1'b0;
            state_q <= lfg_pkg::LFG_LINE;
          end
        end
        lfg_pkg::LFG_LINE: begin
          if (line_ack) begin
            // every line, the last one too, must stay in the start region
            if (line_addr_q[31:`LFG_REGION_LSB] != geom.start_addr[31:`LFG_REGION_LSB]) begin
              region_err_q <= 1'b1;
            end
            state_q <= last_line ? lfg_pkg::LFG_IDLE : lfg_pkg::LFG_NEXT;
          end
        end
        lfg_pkg::LFG_NEXT: begin
          line_addr_q <= line_addr_q + line_step; // [R10]
          line_idx_q <= line_idx_q + 9'h001;
          state_q <= lfg_pkg::LFG_LINE;
        end
        default: state_q <= lfg_pkg::LFG_IDLE;
      endcase
    end
  end
  AST_LINE_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == lfg_pkg::LFG_NEXT) |=> (line_addr_q == $past(line_addr_q) + $past(line_step)))
    else $error("line address did not advance by page width"); // [R10]
  AST_FRAME_BASE: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == lfg_pkg::LFG_IDLE && frame_start) |=>
      (line_addr_q == {$past(geom.start_addr[31:1]), 1'b0} && line_idx_q == 9'h000))
    else $error("frame did not start at start address"); // [R1]
  AST_LINE_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
    (line_req && line_ack && last_line) |=> (state_q == lfg_pkg::LFG_IDLE))
    else $error("frame did not end after height plus one lines"); // [R8]
  AST_ADDR_EVEN: assert property (@(posedge aclk) disable iff (!aresetn)
    line_req |-> (line_addr_q[0] == 1'b0))
    else $error("odd fetch address"); // [R1]
  AST_GRAY_LEGAL: assert property (@(posedge aclk) disable iff (!aresetn)
    geom.gray_mode_select != lfg_pkg::LFG_GS_RSVD)
    else $error("reserved gray mode reached fetch side"); // [R9]
  AST_WIDTH_ALIGN: assert property (@(posedge aclk) disable iff (!aresetn)
    geom.width_px[3:0] == 4'h0)
    else $error("panel width not a whole multiple of sixteen"); // [R7]
  COV_FRAME_END: cover property (@(posedge aclk) disable iff (!aresetn)
    line_req && line_ack && last_line);
  COV_MULTI_LINE: cover property (@(posedge aclk) disable iff (!aresetn)
    (state_q == lfg_pkg::LFG_NEXT) ##2 (state_q == lfg_pkg::LFG_NEXT));
endmodule
`default_nettype wire

// file: tb/lfg_mem_model.sv
// Purpose: pixel fetch memory side, acknowledges line requests
// Assumes: ack latency chosen by the bench per frame
// Notes: ack only while a request stands
`timescale 1ns/1ps
`default_nettype none
module lfg_mem_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // line handshake
  input wire logic line_req,
  input wire logic [3:0] lat,
  output logic line_ack
);
  logic [3:0] wait_q;
  assign line_ack = line_req && (wait_q >= lat);
  always_ff @(posedge aclk) begin
    if (!aresetn || !line_req || line_ack) begin
      wait_q <= 4'h0;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

// file: tb/lfg_frame_geometry_regs_test.sv
// Purpose: register and line fetch checks for frame geometry block
// Assumes: 50 MHz aclk, bench acts as AXI4-Lite master
// Notes: memory model sets line ack latency
`timescale 1ns/1ps
`default_nettype none
`include "lfg_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t got %h expected %h", $time, g, e); end end
module lfg_frame_geometry_regs_test;
  localparam logic [1:0] ok = `LFG_RESP_OKAY;
  logic aclk, aresetn, frame_start, line_req, line_ack;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, line_addr;
  logic [3:0] s_axi_wstrb, lat;
  logic [1:0] s_axi_bresp, s_axi_rresp, gray_mode_select;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [8:0] line_idx;
  int failures = 0;
  int comparisons = 0;
  lfg_frame_geometry_regs #(.ADDR_W(16)) u_dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .frame_start, .line_req, .line_ack, .line_addr, .line_idx,
    .gray_mode_select);
  lfg_mem_model u_mem (.aclk, .aresetn, .line_req, .lat, .line_ack);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic conclude();
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    `CHK(s_axi_bresp, er)
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    `CHK(s_axi_rdata, ed)
    `CHK(s_axi_rresp, er)
    s_axi_rready <= 1'b0;
  endtask
  // one frame, second start request while busy must be ignored
  task automatic frame(input logic [3:0] l, input int nl, input logic [31:0] s,
    input logic [7:0] v);
    @(posedge aclk);
    lat <= l;
    frame_start <= 1'b1;
    @(posedge aclk);
    frame_start <= 1'b0;
    for (int k = 0; k < nl; k++) begin
      do @(posedge aclk); while (!(line_req && line_ack));
      `CHK(line_addr, s + 32'(k) * {23'h0, v, 1'b0})
      `CHK(line_idx, 9'(k))
      frame_start <= (k == 0);
    end
    repeat (8) begin
      @(posedge aclk);
      `CHK(line_req, 1'b0)
    end
  endtask
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    frame_start = 1'b0;
    s_axi_awaddr = 16'h0000;
    s_axi_araddr = 16'h0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    lat = 4'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(`LFG_OFS_START + 16'(4 * i), 32'h0, ok);
    wr(`LFG_OFS_START, 32'h0012_3457, ok);
    rd(`LFG_OFS_START, 32'h0012_3456, ok);
    wr(`LFG_OFS_VPW, 32'hffff_ffab, ok);
    rd(`LFG_OFS_VPW, 32'h0000_00ab, ok);
    wr(`LFG_OFS_WIDTH, 32'hffff_ffff, ok);
    rd(`LFG_OFS_WIDTH, 32'h0000_03f0, ok);
    wr(`LFG_OFS_HEIGHT, 32'hffff_ffff, ok);
    rd(`LFG_OFS_HEIGHT, 32'h0000_01ff, ok);
    for (int m = 0; m < 3; m++) begin
      wr(`LFG_OFS_MODE, 32'(m), ok);
      rd(`LFG_OFS_MODE, 32'(m), ok);
      `CHK(gray_mode_select, 2'(m))
    end
    wr(`LFG_OFS_MODE, 32'h3, ok);
    rd(`LFG_OFS_MODE, 32'h2, ok);
    wr(16'hfa20, 32'h1, `LFG_RESP_SLVERR);
    rd(16'hfa20, 32'h0, `LFG_RESP_SLVERR);
    // 320 pixels, four-level gray, three lines
    wr(`LFG_OFS_MODE, 32'h1, ok);
    wr(`LFG_OFS_START, 32'h0010_0000, ok);
    wr(`LFG_OFS_WIDTH, 32'd320, ok);
    wr(`LFG_OFS_VPW, 32'd40, ok);
    wr(`LFG_OFS_HEIGHT, 32'd2, ok);
    frame(4'h0, 3, 32'h0010_0000, 8'd40);
    frame(4'h3, 3, 32'h0010_0000, 8'd40);
    rd(`LFG_OFS_STATUS, 32'h0, ok);
    // image deliberately straddles a 1 Mbyte boundary
    wr(`LFG_OFS_START, 32'h000f_ffc0, ok);
    frame(4'h2, 3, 32'h000f_ffc0, 8'd40);
    rd(`LFG_OFS_STATUS, 32'h2, ok);
    conclude();
  end
  initial begin
    repeat (5000) @(posedge aclk);
    failures++;
    conclude();
  end
endmodule
`default_nettype wire
